// File: bench/burst_sram_port_test.sv
`timescale 1ns/1ps
module burst_sram_port_test;
   import sram_port_pkg::*;
   logic                       sys_clk, rst, burst_interleave;
   logic                       clk_qualify_n, chip_sel1_n, chip_sel2, chip_sel3_n;
   logic                       advance_or_load, write_en_n, out_en_n, sleep_req;
   logic                       data_oe_n, asleep;
   logic [LANES-1:0]           byte_sel_n, write_parity, read_parity;
   logic [ADDR_BITS-1:0]       addr, ba;
   logic [LANES*DATA_BITS-1:0] write_data, read_data;
   logic [35:0]                ref_m [int];
   int                         fail_count, n_tests;

   burst_sram_port i_dut (.sys_clk, .rst, .clk_qualify_n, .chip_sel1_n, .chip_sel2,
      .chip_sel3_n, .advance_or_load, .write_en_n, .byte_sel_n, .addr, .write_data,
      .write_parity, .out_en_n, .burst_interleave, .sleep_req, .read_data, .read_parity,
      .data_oe_n, .asleep);
   sram_host_model i_host (.sys_clk, .clk_qualify_n, .chip_sel1_n, .chip_sel2,
      .chip_sel3_n, .advance_or_load, .write_en_n, .byte_sel_n, .addr, .write_data,
      .write_parity, .out_en_n, .sleep_req);

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Reference memory follows the byte selects of every write
   task automatic wr(input logic [1:0] k, input logic [ADDR_BITS-1:0] a,
                     input logic [3:0] bs, input logic [35:0] d);
      logic [35:0] m;
      m = '0;
      for (int g = 0; g < 4; g++) begin
         m[g*8 +: 8] = {8{~bs[g]}};
         m[32+g]     = ~bs[g];
      end
      i_host.step(k, a, bs, d);
      ref_m[a] = (ref_m[a] & ~m) | (d & m);
   endtask

   task automatic rd(input logic [ADDR_BITS-1:0] a);
      i_host.step(2'd1, a, 4'hF, '0);
      i_host.step(2'd0, a, 4'hF, '0);
      chk("read", ref_m[a], {read_parity, read_data});
      chk("drive", 36'h0, 36'(data_oe_n));
   endtask

   // Beat address worked out independently of the design
   function automatic logic [ADDR_BITS-1:0] beat(input logic [ADDR_BITS-1:0] s, input int b);
      logic [1:0] o;
      o = burst_interleave ? (s[1:0] ^ 2'(b)) : (s[1:0] + 2'(b));
      return {s[ADDR_BITS-1:2], o};
   endfunction

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      burst_interleave = 1'b0;
      fail_count = 0;
      n_tests = 0;
      repeat (5) @(negedge sys_clk);
      chk("rest_data", 36'h0, {read_parity, read_data});
      chk("rest_oe", 36'h1, 36'(data_oe_n));
      chk("rest_sleep", 36'h0, 36'(asleep));
      rst = 1'b0;
      // Every byte select combination, all-off last
      for (int bs = 0; bs < 16; bs++) begin
         wr(2'd2, 18'h0_0040, 4'(bs), 36'(bs) * 36'h1_1111_1111);
         rd(18'h0_0040);
      end
      // Read, write, read with no idle cycle
      i_host.step(2'd1, 18'h0_0040, 4'hF, '0);
      wr(2'd2, 18'h0_0041, 4'h0, 36'h5_A5A5_1234);
      chk("rd_first", ref_m[18'h0_0040], {read_parity, read_data});
      i_host.step(2'd1, 18'h0_0041, 4'hF, '0);
      chk("wr_float", 36'h1, 36'(data_oe_n));
      i_host.step(2'd0, 18'h0_0041, 4'hF, '0);
      chk("fwd", ref_m[18'h0_0041], {read_parity, read_data});
      chk("fwd_oe", 36'h0, 36'(data_oe_n));
      i_host.step(2'd0, 18'h0_0041, 4'hF, '0);
      chk("desel", 36'h1, 36'(data_oe_n));
      // Stalled edges ignore the commands presented on them
      i_host.step(2'd1, 18'h0_0040, 4'hF, '0);
      i_host.stall = 1'b1;
      i_host.step(2'd1, 18'h0_0041, 4'hF, '0);
      i_host.step(2'd2, 18'h0_0041, 4'h0, '0);
      chk("stall", 36'h1, 36'(data_oe_n));
      i_host.stall = 1'b0;
      i_host.step(2'd0, 18'h0_0041, 4'hF, '0);
      chk("stall_rd", ref_m[18'h0_0040], {read_parity, read_data});
      i_host.oe_hi = 1'b1;
      i_host.step(2'd1, 18'h0_0041, 4'hF, '0);
      i_host.step(2'd0, 18'h0_0041, 4'hF, '0);
      chk("oe_off", 36'h1, 36'(data_oe_n));
      i_host.oe_hi = 1'b0;
      // Strap only changes while idle
      for (int il = 0; il < 2; il++) begin
         burst_interleave = il[0];
         ba = il[0] ? 18'h0_0211 : 18'h0_0103;
         for (int b = 0; b < 4; b++)
            wr(b > 0 ? 2'd3 : 2'd2, beat(ba, b), 4'h0,
               36'h3_0000_0000 + 36'(b + il * 16));
         for (int b = 0; b < 4; b++)
            rd(beat(ba, b));
         for (int b = 0; b < 5; b++) begin
            i_host.step(b == 0 ? 2'd1 : (b < 4 ? 2'd3 : 2'd0), ba, 4'hF, '0);
            if (b > 0) chk("burst", ref_m[beat(ba, b - 1)], {read_parity, read_data});
         end
      end
      // Host stays deselected through entry and recovery
      i_host.zz = 1'b1;
      for (int c = 1; c <= 4; c++) begin
         if (c == 3) i_host.zz = 1'b0;
         i_host.step(2'd0, '0, 4'hF, '0);
         chk("asleep", 36'(c == 2 || c == 3), 36'(asleep));
      end
      rd(18'h0_0103);
      wrap_up();
   end
endmodule

// File: bench/sram_host_model.sv
`timescale 1ns/1ps
module sram_host_model
   import sram_port_pkg::*;
(
   input  wire logic                       sys_clk,
   output logic                            clk_qualify_n,
   output logic                            chip_sel1_n,
   output logic                            chip_sel2,
   output logic                            chip_sel3_n,
   output logic                            advance_or_load,
   output logic                            write_en_n,
   output logic [LANES-1:0]                byte_sel_n,
   output logic [ADDR_BITS-1:0]            addr,
   output logic [LANES*DATA_BITS-1:0]      write_data,
   output logic [LANES-1:0]                write_parity,
   output logic                            out_en_n,
   output logic                            sleep_req
);
   logic        stall, oe_hi, zz, bw, wv1, wv2;
   logic [35:0] wd1, wd2;

   initial begin
      {stall, oe_hi, zz, bw, wv1, wv2} = 6'h00;
      {wd1, wd2} = '0;
      {clk_qualify_n, advance_or_load, out_en_n, sleep_req} = 4'h0;
      {chip_sel1_n, chip_sel2, chip_sel3_n, write_en_n} = 4'hB;
      byte_sel_n = 4'hF;
      addr = '0;
      {write_parity, write_data} = 36'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One command per cycle: 0 deselect, 1 read, 2 write, 3 advance
   task automatic step(input logic [1:0] k, input logic [ADDR_BITS-1:0] a,
                       input logic [3:0] bs, input logic [35:0] d);
      clk_qualify_n   = stall;
      // Output enable as the bench asks
      out_en_n        = oe_hi;
      sleep_req       = zz;
      advance_or_load = (k == 2'd3);
      {chip_sel1_n, chip_sel2, chip_sel3_n} = (k == 2'd1 || k == 2'd2) ? 3'h2 : 3'h5;
      write_en_n      = (k != 2'd2);
      // Selects per beat; address junk while advancing
      byte_sel_n      = bs;
      addr            = (k == 2'd3) ? ~a : a;
      if (!stall) begin
         // Data two edges after its command, else a changing pattern
         {write_parity, write_data} = wv2 ? wd2 : ~{write_parity, write_data};
         wv2 = wv1;
         wd2 = wd1;
         if (k != 2'd3) bw = (k == 2'd2);
         wv1 = bw;
         wd1 = d;
      end
      @(negedge sys_clk);
   endtask
endmodule

// File: pkg/sram_port_pkg.sv
package sram_port_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Geometry
   localparam int ADDR_BITS = 18;
   localparam int LANES     = 4;
   localparam int DATA_BITS = 8;
   localparam int LANE_BITS = DATA_BITS + 1;
   localparam int BEAT_BITS = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing, in clock cycles of 8 ns
   localparam int SLEEP_CYC = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and counter step
   localparam logic                 OE_OFF   = 1'b1;
   localparam logic [1:0]           SLP_CNT0 = 2'h0;
   localparam logic [BEAT_BITS-1:0] BEAT_ONE = 2'h1;

   typedef enum logic [1:0] {
      SLP_AWAKE  = 2'b00,
      SLP_ENTER  = 2'b01,
      SLP_ASLEEP = 2'b11,
      SLP_WAKE   = 2'b10
   } sleep_st_t;

   typedef struct packed {
      logic                 valid;
      logic                 wr;
      logic [ADDR_BITS-1:0] addr;
      logic [LANES-1:0]     bsel_n;
   } cmd_t;

   typedef struct packed {
      logic                 active;
      logic                 wr;
      logic [ADDR_BITS-1:0] base;
      logic [BEAT_BITS-1:0] beat;
   } burst_t;

   typedef struct packed {
      burst_t                     burst;
      cmd_t                       s1;
      cmd_t                       s2;
      logic [LANES*DATA_BITS-1:0] dout;
      logic [LANES-1:0]           pout;
      logic                       oe_n;
      sleep_st_t                  slp;
      logic [1:0]                 slp_cnt;
      logic                       asleep;
   } state_t;

   localparam state_t STATE_RST = '{oe_n: OE_OFF, slp: SLP_AWAKE, default: '0};

   // Low address bits of a burst beat
   // Interleaved: start XOR beat
   function automatic logic [1:0] burst_low(input logic [1:0] start,
                                            input logic [1:0] beat,
                                            input logic       interleave);
      return interleave ? (start ^ beat) : 2'(start + beat);
   endfunction

endpackage

// File: rtl/burst_sram_port.sv
`timescale 1ns/1ps
module burst_sram_port
   import sram_port_pkg::*;
#(
   parameter int ADDR_W       = ADDR_BITS,
   parameter int NUM_LANES    = LANES,
   parameter int SLEEP_CYCLES = SLEEP_CYC
) (
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   input  wire logic                           clk_qualify_n,
   input  wire logic                           chip_sel1_n,
   input  wire logic                           chip_sel2,
   input  wire logic                           chip_sel3_n,
   input  wire logic                           advance_or_load,
   input  wire logic                           write_en_n,
   input  wire logic [NUM_LANES-1:0]           byte_sel_n,
   input  wire logic [ADDR_W-1:0]              addr,
   input  wire logic [NUM_LANES*DATA_BITS-1:0] write_data,
   input  wire logic [NUM_LANES-1:0]           write_parity,
   input  wire logic                           out_en_n,
   input  wire logic                           burst_interleave,
   input  wire logic                           sleep_req,
   output logic      [NUM_LANES*DATA_BITS-1:0] read_data,
   output logic      [NUM_LANES-1:0]           read_parity,
   output logic                                data_oe_n,
   output logic                                asleep
);

   if (ADDR_W != ADDR_BITS || NUM_LANES != LANES || SLEEP_CYCLES < 2
       || SLEEP_CYCLES > 3) begin : g_bad
      $error("burst_sram_port: unsupported parameters");
   end

   localparam logic [1:0] SLP_LAST = 2'(SLEEP_CYCLES - 1);

   state_t                      st_r;
   state_t                      st_nxt;
   logic                        ce;
   logic                        all_sel;
   logic                        halted;
   logic                        rd_now;
   logic [LANES-1:0]            mem_we;
   logic [LANES*LANE_BITS-1:0]  wword;
   logic [LANES*LANE_BITS-1:0]  rword;
   logic [LANES*LANE_BITS-1:0]  fwd;

   assign ce      = !clk_qualify_n;
   assign all_sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
   // A high sleep input, or any sleep state other than SLP_AWAKE, halts
   assign halted  = sleep_req || (st_r.slp != SLP_AWAKE);
   assign rd_now  = st_r.s1.valid && !st_r.s1.wr;

   ////////////////////////////////////////////////////////////////////////////////
   // Write port and read forwarding
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign wword[g*LANE_BITS +: LANE_BITS] = {write_parity[g],
                                                write_data[g*DATA_BITS +: DATA_BITS]};
      assign mem_we[g] = ce && !halted && st_r.s2.valid && !st_r.s2.bsel_n[g];
      // Read of a word being written this edge sees the new lanes
      assign fwd[g*LANE_BITS +: LANE_BITS] =
         (mem_we[g] && st_r.s2.addr == st_r.s1.addr) ?
         wword[g*LANE_BITS +: LANE_BITS] : rword[g*LANE_BITS +: LANE_BITS];
   end

   sram_array #(
      .AW    (ADDR_BITS),
      .LANES (LANES),
      .LW    (LANE_BITS)
   ) u_array (
      .clk   (sys_clk),
      .we    (mem_we),
      .waddr (st_r.s2.addr),
      .wdata (wword),
      .raddr (st_r.s1.addr),
      .rdata (rword)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_nxt = st_r;

      case (st_r.slp)
         SLP_AWAKE: begin
            if (sleep_req) begin
               st_nxt.slp     = SLP_ENTER;
               st_nxt.slp_cnt = BEAT_ONE;
            end
         end
         SLP_ENTER: begin
            if (!sleep_req) begin
               st_nxt.slp = SLP_AWAKE;
            end else if (st_r.slp_cnt == SLP_LAST) begin
               st_nxt.slp = SLP_ASLEEP;
            end else begin
               st_nxt.slp_cnt = 2'(st_r.slp_cnt + BEAT_ONE);
            end
         end
         SLP_ASLEEP: begin
            if (!sleep_req) begin
               st_nxt.slp     = SLP_WAKE;
               st_nxt.slp_cnt = BEAT_ONE;
            end
         end
         SLP_WAKE: begin
            if (sleep_req) begin
               st_nxt.slp = SLP_ASLEEP;
            end else if (st_r.slp_cnt == SLP_LAST) begin
               st_nxt.slp = SLP_AWAKE;
            end else begin
               st_nxt.slp_cnt = 2'(st_r.slp_cnt + BEAT_ONE);
            end
         end
         default: begin
            st_nxt.slp     = SLP_AWAKE;
            st_nxt.slp_cnt = SLP_CNT0;
         end
      endcase
      // Flag stays up through recovery, while commands are still refused
      st_nxt.asleep = (st_nxt.slp == SLP_ASLEEP) || (st_nxt.slp == SLP_WAKE);

      if (halted) begin
         // Pending accesses are dropped; the array keeps its contents
         st_nxt.burst.active = 1'b0;
         st_nxt.s1.valid     = 1'b0;
         st_nxt.s2.valid     = 1'b0;
         st_nxt.oe_n         = OE_OFF;
      end else if (ce) begin
         if (!advance_or_load) begin
            st_nxt.burst.active = all_sel;
            st_nxt.burst.wr     = !write_en_n;
            st_nxt.burst.base   = addr;
            st_nxt.burst.beat   = '0;
            st_nxt.s1.valid     = all_sel;
            st_nxt.s1.wr        = !write_en_n;
            st_nxt.s1.addr      = addr;
         end else begin
            st_nxt.burst.beat = 2'(st_r.burst.beat + BEAT_ONE);
            st_nxt.s1.valid   = st_r.burst.active;
            st_nxt.s1.wr      = st_r.burst.wr;
            st_nxt.s1.addr    = {st_r.burst.base[ADDR_BITS-1:2],
                                 burst_low(st_r.burst.base[1:0], st_nxt.burst.beat,
                                           burst_interleave)};
         end
         st_nxt.s1.bsel_n = byte_sel_n;

         st_nxt.s2       = st_r.s1;
         st_nxt.s2.valid = st_r.s1.valid && st_r.s1.wr;

         if (rd_now) begin
            for (int i = 0; i < LANES; i++) begin
               st_nxt.dout[i*DATA_BITS +: DATA_BITS] = fwd[i*LANE_BITS +: DATA_BITS];
               st_nxt.pout[i] = fwd[i*LANE_BITS + DATA_BITS];
            end
         end
         st_nxt.oe_n = !(rd_now && !out_en_n);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r <= STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign read_data   = st_r.dout;
   assign read_parity = st_r.pout;
   assign data_oe_n   = st_r.oe_n;
   assign asleep      = st_r.asleep;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic rd_go;
   logic wr_go;
   logic desel_go;
   logic run;
   assign run      = ce && !halted;
   assign rd_go    = run && !advance_or_load && all_sel && write_en_n;
   assign wr_go    = run && !advance_or_load && all_sel && !write_en_n;
   assign desel_go = run && !advance_or_load && !all_sel;

   read_drive_a: assert property (rd_go ##1 (run && !out_en_n) |=> !data_oe_n)
      else $error("read data not driven");
   write_float_a: assert property (wr_go ##1 run |=> data_oe_n)
      else $error("bus driven in write data cycle");
   desel_float_a: assert property (desel_go ##1 run |=> data_oe_n)
      else $error("bus driven after deselect");
   stall_hold_a: assert property (!ce && !halted |=> $stable(st_r.burst) && $stable(st_r.s1)
                                  && $stable(read_data))
      else $error("state moved on a disabled edge");
   beat_step_a: assert property (run && advance_or_load |=>
                                 st_r.burst.beat == 2'($past(st_r.burst.beat) + 2'h1))
      else $error("burst counter did not advance");
   dir_keep_a: assert property (run && advance_or_load |=>
                                st_r.s1.wr == $past(st_r.burst.wr))
      else $error("burst direction changed");
   burst_seq_a: assert property (run && advance_or_load |=>
      st_r.s1.addr == {$past(st_r.burst.base[ADDR_BITS-1:2]),
         ($past(burst_interleave) ? ($past(st_r.burst.base[1:0]) ^ st_r.burst.beat)
                                  : 2'($past(st_r.burst.base[1:0]) + st_r.burst.beat))})
      else $error("burst address sequence wrong");
   lane_mask_a: assert property (st_r.s2.valid && &st_r.s2.bsel_n |-> mem_we == '0)
      else $error("write with no lanes updated memory");
   sleep_entry_a: assert property (!asleep && sleep_req [*2] |=> asleep)
      else $error("sleep not entered in two cycles");
   sleep_float_a: assert property (sleep_req |=> data_oe_n)
      else $error("bus driven while sleeping");

   cov_read_c: cover property (rd_go ##1 (run && !out_en_n) ##1 !data_oe_n);
   cov_burst_c: cover property (wr_go ##1 (run && advance_or_load) [*3]);
   cov_sleep_c: cover property (asleep ##1 !sleep_req [*2] ##1 !asleep);
endmodule

// File: rtl/sram_array.sv
`timescale 1ns/1ps
module sram_array #(
   parameter int AW    = 18,
   parameter int LANES = 4,
   parameter int LW    = 9
) (
   input  wire logic                  clk,
   input  wire logic [LANES-1:0]      we,
   input  wire logic [AW-1:0]         waddr,
   input  wire logic [LANES*LW-1:0]   wdata,
   input  wire logic [AW-1:0]         raddr,
   output logic      [LANES*LW-1:0]   rdata
);

   if (AW < 2 || LANES < 1 || LW < 1) begin : g_bad
      $error("sram_array: unsupported geometry");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One array per lane so each lane writes alone
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [LW-1:0] mem [0:(1<<AW)-1];

      always_ff @(posedge clk) begin
         if (we[g]) begin
            mem[waddr] <= wdata[g*LW +: LW];
         end
      end

      assign rdata[g*LW +: LW] = mem[raddr];
   end

endmodule
